// >>> cmpcr_consts.svh
/*
  offsets, field positions, reset values and codes of the comparator control registers.
  assumes it is included by the register bank module of this block; the package does not include it.
*/
`ifndef CMPCR_CONSTS_SVH
`define CMPCR_CONSTS_SVH

// special-function-register addresses
`define CMPCR_CONTROL_ADDR 8'h9a
`define CMPCR_MODE_ADDR 8'h9c
`define CMPCR_INSEL_ADDR 8'h9e

// reset values
`define CMPCR_CONTROL_RESET 8'h00
`define CMPCR_MODE_RESET 8'h02
`define CMPCR_INSEL_RESET 8'hff

// control register fields
`define CMPCR_CTL_ON_BIT 7
`define CMPCR_CTL_RESULT_BIT 6
`define CMPCR_CTL_RISE_BIT 5
`define CMPCR_CTL_FALL_BIT 4

// mode register fields
`define CMPCR_MODE_RIE_BIT 5
`define CMPCR_MODE_FIE_BIT 4
`define CMPCR_MODE_WMASK 8'h33

`endif

// >>> cmpcr_pkg.sv
/*
  types shared by the comparator control register bank.
  assumes cmpcr_consts.svh provides the numeric constants.
*/
`default_nettype none
package cmpcr_pkg;
  // response mode: 0 fastest, 3 lowest power
  typedef enum logic [1:0] {
    CMPCR_FASTEST,
    CMPCR_MODE1,
    CMPCR_MODE2,
    CMPCR_LOW_POWER
  } cmpcr_resp_type;
  // hysteresis amount: off, 5, 10, 20 mV
  typedef enum logic [1:0] {
    CMPCR_HYST_OFF,
    CMPCR_HYST_5MV,
    CMPCR_HYST_10MV,
    CMPCR_HYST_20MV
  } cmpcr_hyst_type;
endpackage
`default_nettype wire

// >>> cmpcr_edge_detect.sv
/*
  synchroniser and edge detector for the raw comparator output.
  assumes rawResult is asynchronous to clk.
*/
`default_nettype none
module cmpcr_edge_detect (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // raw comparator output
  input wire logic rawResult,
  // synchronised level and edge pulses
  output logic syncResult,
  output logic risePulse,
  output logic fallPulse
);
  logic meta;
  logic prevResult;

  // two-flop synchroniser, then one delay stage for edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b0;
      syncResult <= 1'b0;
      prevResult <= 1'b0;
    end else begin
      meta <= rawResult;
      syncResult <= meta;
      prevResult <= syncResult;
    end
  end

  assign risePulse = syncResult & ~prevResult;
  assign fallPulse = ~syncResult & prevResult;
endmodule
`default_nettype wire

// >>> cmpcr_regs.sv
/*
  control and status register bank for the second voltage comparator.
  assumes a special-function-register bus with one-cycle write and read strobes
  and an analog comparator that takes the enable, hysteresis and mode codes.
*/
`include "cmpcr_consts.svh"
`default_nettype none
// What this block does
// - mode bit 7 always reads zero
// - mode bits 6,3,2 read zero, writes ignored
// - mode bits 5,4 enable rise/fall interrupts
// - mode bits 1..0 response code, reset 02
// - control bit 7 enables comparator, reset zero
// - control bit 6 reads synchronised result
// - rise flag set on rising edge, sticky
// - fall flag set on falling edge, sticky
// - control bits 3..2 positive hysteresis code
// - control bits 1..0 negative hysteresis code
// - four-bit positive and negative input selects
// - disabled comparator drives pin output low
module cmpcr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // special-function-register bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // analog comparator
  input wire logic cmpRawResult,
  output logic cmpOn,
  output cmpcr_pkg::cmpcr_hyst_type posHystCode,
  output cmpcr_pkg::cmpcr_hyst_type negHystCode,
  output cmpcr_pkg::cmpcr_resp_type responseModeCode,
  output logic [3:0] posInputSel,
  output logic [3:0] negInputSel,
  // system side
  output logic cmpPinOut,
  output logic cmpIrq
);
  logic syncResult;
  logic risePulse;
  logic fallPulse;
  logic riseSeenFlag;
  logic fallSeenFlag;
  logic riseIrqEn;
  logic fallIrqEn;
  logic ctlWrite;
  logic modeWrite;
  logic selWrite;
  logic next_riseSeenFlag;
  logic next_fallSeenFlag;

  // true when the bus address selects the given register
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] regAddr);
    return addr == regAddr;
  endfunction

  cmpcr_edge_detect u_edge (
    .clk(clk),
    .rstn(rstn),
    .rawResult(cmpRawResult),
    .syncResult(syncResult),
    .risePulse(risePulse),
    .fallPulse(fallPulse)
  );

  // address decode of the three registers
  assign ctlWrite = sfrWrite && addr_hit(sfrAddr, `CMPCR_CONTROL_ADDR);
  assign modeWrite = sfrWrite && addr_hit(sfrAddr, `CMPCR_MODE_ADDR);
  assign selWrite = sfrWrite && addr_hit(sfrAddr, `CMPCR_INSEL_ADDR);

  // enable and hysteresis fields of the control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmpOn <= 1'b0;
      posHystCode <= cmpcr_pkg::CMPCR_HYST_OFF;
      negHystCode <= cmpcr_pkg::CMPCR_HYST_OFF;
    end else if (ctlWrite) begin
      cmpOn <= sfrWdata[`CMPCR_CTL_ON_BIT];
      posHystCode <= cmpcr_pkg::cmpcr_hyst_type'(sfrWdata[3:2]);
      negHystCode <= cmpcr_pkg::cmpcr_hyst_type'(sfrWdata[1:0]);
    end
  end

  // sticky edge flags: a hardware edge wins over a software clear
  always_comb begin
    next_riseSeenFlag = riseSeenFlag;
    next_fallSeenFlag = fallSeenFlag;
    if (ctlWrite) begin
      next_riseSeenFlag = sfrWdata[`CMPCR_CTL_RISE_BIT];
      next_fallSeenFlag = sfrWdata[`CMPCR_CTL_FALL_BIT];
    end
    if (risePulse) begin
      next_riseSeenFlag = 1'b1;
    end
    if (fallPulse) begin
      next_fallSeenFlag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      riseSeenFlag <= 1'b0;
      fallSeenFlag <= 1'b0;
    end else begin
      riseSeenFlag <= next_riseSeenFlag;
      fallSeenFlag <= next_fallSeenFlag;
    end
  end

  // mode register: only interrupt enables and response code are stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      riseIrqEn <= 1'b0;
      fallIrqEn <= 1'b0;
      responseModeCode <= cmpcr_pkg::CMPCR_MODE2;
    end else if (modeWrite) begin
      riseIrqEn <= sfrWdata[`CMPCR_MODE_RIE_BIT];
      fallIrqEn <= sfrWdata[`CMPCR_MODE_FIE_BIT];
      responseModeCode <= cmpcr_pkg::cmpcr_resp_type'(sfrWdata[1:0]);
    end
  end

  // input select register: negative in the high nibble
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      posInputSel <= 4'(`CMPCR_INSEL_RESET); // low nibble of the reset byte
      negInputSel <= 4'(`CMPCR_INSEL_RESET >> 4); // high nibble of the reset byte
    end else if (selWrite) begin
      posInputSel <= sfrWdata[3:0];
      negInputSel <= sfrWdata[7:4];
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfrRdata <= 8'h00;
    end else if (sfrRead) begin
      case (sfrAddr)
        `CMPCR_CONTROL_ADDR: sfrRdata <= {cmpOn, syncResult, riseSeenFlag, fallSeenFlag,
                                           posHystCode, negHystCode};
        `CMPCR_MODE_ADDR: sfrRdata <= {2'h0, riseIrqEn, fallIrqEn, 2'h0,
                                       responseModeCode} & `CMPCR_MODE_WMASK;
        `CMPCR_INSEL_ADDR: sfrRdata <= {negInputSel, posInputSel};
        default: sfrRdata <= 8'h00;
      endcase
    end
  end

  // pin output held low while disabled; interrupt from enabled flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmpPinOut <= 1'b0;
      cmpIrq <= 1'b0;
    end else begin
      cmpPinOut <= cmpOn & syncResult;
      cmpIrq <= (next_riseSeenFlag & riseIrqEn) | (next_fallSeenFlag & fallIrqEn);
    end
  end

  property p_rise_sets;
    @(posedge clk) disable iff (!rstn) risePulse |=> riseSeenFlag;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise flag missed edge");

  property p_fall_sets;
    @(posedge clk) disable iff (!rstn) fallPulse |=> fallSeenFlag;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall flag missed edge");

  property p_rise_sticky;
    @(posedge clk) disable iff (!rstn) riseSeenFlag && !ctlWrite |=> riseSeenFlag;
  endproperty
  a_rise_sticky: assert property (p_rise_sticky) else $error("rise flag dropped");

  property p_mode_read_zero;
    @(posedge clk) disable iff (!rstn)
      sfrRead && sfrAddr == `CMPCR_MODE_ADDR |=> (sfrRdata & 8'hcc) == 8'h00;
  endproperty
  a_mode_read_zero: assert property (p_mode_read_zero) else $error("mode pad bits set");

  property p_mode_write;
    @(posedge clk) disable iff (!rstn)
      modeWrite |=> riseIrqEn == $past(sfrWdata[5]) && responseModeCode == $past(sfrWdata[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_pin_low_off;
    @(posedge clk) disable iff (!rstn) !cmpOn |=> !cmpPinOut;
  endproperty
  a_pin_low_off: assert property (p_pin_low_off) else $error("pin high while off");

  property p_irq;
    @(posedge clk) disable iff (!rstn)
      ##1 cmpIrq == (($past(next_riseSeenFlag) && $past(riseIrqEn)) ||
                     ($past(next_fallSeenFlag) && $past(fallIrqEn)));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_result_read;
    @(posedge clk) disable iff (!rstn)
      sfrRead && sfrAddr == `CMPCR_CONTROL_ADDR |=> sfrRdata[6] == $past(syncResult);
  endproperty
  a_result_read: assert property (p_result_read) else $error("result bit wrong");

  property p_sync_delay;
    @(posedge clk) disable iff (!rstn) $rose(syncResult) |-> $past(cmpRawResult, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync path wrong");

  // fall flag holds until software writes the control register
  property p_fall_sticky;
    @(posedge clk) disable iff (!rstn) fallSeenFlag && !ctlWrite |=> fallSeenFlag;
  endproperty
  a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag dropped");

  // a control write lands the enable and both hysteresis codes
  property p_ctl_write;
    @(posedge clk) disable iff (!rstn)
      ctlWrite |=> cmpOn == $past(sfrWdata[7]) && posHystCode == $past(sfrWdata[3:2])
        && negHystCode == $past(sfrWdata[1:0]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

  // an input select write lands both four-bit fields
  property p_sel_write;
    @(posedge clk) disable iff (!rstn)
      selWrite |=> posInputSel == $past(sfrWdata[3:0])
        && negInputSel == $past(sfrWdata[7:4]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write lost");

  // a mode read returns the stored enables and response code
  property p_mode_read_fields;
    @(posedge clk) disable iff (!rstn)
      sfrRead && sfrAddr == `CMPCR_MODE_ADDR |=> sfrRdata[5] == $past(riseIrqEn)
        && sfrRdata[4] == $past(fallIrqEn)
        && sfrRdata[1:0] == $past(responseModeCode);
  endproperty
  a_mode_read_fields: assert property (p_mode_read_fields) else $error("mode read wrong");

  // while enabled the pin follows the synchronised result
  property p_pin_follows;
    @(posedge clk) disable iff (!rstn) cmpOn |=> cmpPinOut == $past(syncResult);
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pin lost result");

  // a set rising flag with its enable raises the request
  property p_irq_rise;
    @(posedge clk) disable iff (!rstn) riseSeenFlag && riseIrqEn && !ctlWrite |=> cmpIrq;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("rise irq missing");

  // a set falling flag with its enable raises the request
  property p_irq_fall;
    @(posedge clk) disable iff (!rstn) fallSeenFlag && fallIrqEn && !ctlWrite |=> cmpIrq;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("fall irq missing");

  // no flag and no edge leaves the request low
  property p_irq_quiet;
    @(posedge clk) disable iff (!rstn)
      !riseSeenFlag && !fallSeenFlag && !risePulse && !fallPulse && !ctlWrite |=> !cmpIrq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without flag");

  // writing zero clears the rising flag when no edge comes with it
  property p_rise_clear;
    @(posedge clk) disable iff (!rstn)
      ctlWrite && !sfrWdata[5] && !risePulse |=> !riseSeenFlag;
  endproperty
  a_rise_clear: assert property (p_rise_clear) else $error("rise flag not cleared");

  // writing zero clears the falling flag when no edge comes with it
  property p_fall_clear;
    @(posedge clk) disable iff (!rstn)
      ctlWrite && !sfrWdata[4] && !fallPulse |=> !fallSeenFlag;
  endproperty
  a_fall_clear: assert property (p_fall_clear) else $error("fall flag not cleared");

  // a rising edge in the cycle of a clearing write leaves the flag set
  property p_rise_race;
    @(posedge clk) disable iff (!rstn) ctlWrite && risePulse |=> riseSeenFlag;
  endproperty
  a_rise_race: assert property (p_rise_race) else $error("clear beat rise edge");

  // a falling edge in the cycle of a clearing write leaves the flag set
  property p_fall_race;
    @(posedge clk) disable iff (!rstn) ctlWrite && fallPulse |=> fallSeenFlag;
  endproperty
  a_fall_race: assert property (p_fall_race) else $error("clear beat fall edge");

  // a falling synchronised level comes from the raw level two edges back
  property p_sync_fall;
    @(posedge clk) disable iff (!rstn) $fell(syncResult) |-> !$past(cmpRawResult, 2);
  endproperty
  a_sync_fall: assert property (p_sync_fall) else $error("sync fall path wrong");

  // main scenarios: edges, interrupts, the clear race and the pin
  c_rise: cover property (@(posedge clk) disable iff (!rstn) risePulse ##1 cmpIrq);
  c_fall: cover property (@(posedge clk) disable iff (!rstn) fallPulse ##1 fallSeenFlag);
  c_clear_race: cover property (@(posedge clk) disable iff (!rstn) ctlWrite && risePulse);
  c_fall_irq: cover property (@(posedge clk) disable iff (!rstn)
    fallSeenFlag && fallIrqEn ##1 cmpIrq);
  c_pin_on: cover property (@(posedge clk) disable iff (!rstn)
    cmpOn && syncResult ##1 cmpPinOut);
endmodule
`default_nettype wire

// >>> cmpcr_cpu_model.sv
/*
  processor-side model of the register bus: single byte writes and reads.
  assumes the bank registers read data at the edge that takes the read strobe.
*/
`default_nettype none
module cmpcr_cpu_model (
  // clock
  input wire logic clk,
  // register bus
  output logic [7:0] sfrAddr,
  output logic sfrWrite,
  output logic sfrRead,
  output logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus from time zero
  initial begin
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    sfrWdata = 8'h00;
  end
  // one-cycle write strobe, raised and dropped at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clk);
    sfrWrite = 1'b0;
  endtask
  // read strobe; data is registered, so taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clk);
    sfrRead = 1'b0;
    d = sfrRdata;
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
/*
  self-checking bench for the comparator register bank.
  assumes the bus model above and a raw comparator level driven here.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic raw = 1'b0;
  wire logic [7:0] addr;
  wire logic [7:0] wdata;
  wire logic wrS;
  wire logic rdS;
  logic [7:0] rdata;
  logic on;
  logic pin;
  logic irq;
  logic [3:0] psel;
  logic [3:0] nsel;
  cmpcr_pkg::cmpcr_hyst_type ph;
  cmpcr_pkg::cmpcr_hyst_type nh;
  cmpcr_pkg::cmpcr_resp_type rm;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  cmpcr_cpu_model cpu_u (.clk(clk), .sfrAddr(addr), .sfrWrite(wrS), .sfrRead(rdS),
    .sfrWdata(wdata), .sfrRdata(rdata));
  cmpcr_regs dut_u (.clk(clk), .rstn(rstn), .sfrAddr(addr), .sfrWrite(wrS),
    .sfrRead(rdS), .sfrWdata(wdata), .sfrRdata(rdata), .cmpRawResult(raw),
    .cmpOn(on), .posHystCode(ph), .negHystCode(nh), .responseModeCode(rm),
    .posInputSel(psel), .negInputSel(nsel), .cmpPinOut(pin), .cmpIrq(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu_u.rd(a, d);
    chk(d, exp);
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the hundred or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic t_reset();
    rc(8'h9a, 8'h00);
    rc(8'h9c, 8'h02);
    rc(8'h9e, 8'hff);
    chk({6'h0, rm}, 8'h02);
    chk({7'h0, pin}, 8'h00);
    cpu_u.wr(8'h9b, 8'h55);
    rc(8'h9b, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_mode();
    cpu_u.wr(8'h9c, 8'h7f); // top bit kept zero by software
    rc(8'h9c, 8'h33);
    for (int i = 0; i < 4; i++) begin
      cpu_u.wr(8'h9c, 8'(i));
      chk({6'h0, rm}, 8'(i));
    end
    $display("mode test done");
  endtask
  task automatic t_ctrl();
    for (int i = 0; i < 4; i++) begin
      cpu_u.wr(8'h9a, 8'(8'h80 + i * 5));
      chk({4'h0, ph, nh}, 8'(i * 5));
      chk({7'h0, on}, 8'h01);
    end
    cpu_u.wr(8'h9a, 8'h40); // result bit cannot be written
    rc(8'h9a, 8'h00);
    chk({7'h0, on}, 8'h00);
    cpu_u.wr(8'h9e, 8'h5a);
    chk({nsel, psel}, 8'h5a);
    $display("control test done");
  endtask
  task automatic t_edges();
    cpu_u.wr(8'h9a, 8'h80);
    cpu_u.wr(8'h9c, 8'h00);
    cpu_u.wr(8'h9a, 8'h80); // flags cleared after settling
    raw = 1'b1;
    repeat (5) @(negedge clk);
    rc(8'h9a, 8'he0);
    chk({7'h0, pin}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    cpu_u.wr(8'h9c, 8'h20);
    @(negedge clk);
    chk({7'h0, irq}, 8'h01);
    raw = 1'b0;
    repeat (5) @(negedge clk);
    rc(8'h9a, 8'hb0);
    cpu_u.wr(8'h9a, 8'h90); // drop the rise flag, keep the fall flag
    cpu_u.wr(8'h9c, 8'h10);
    @(negedge clk);
    chk({7'h0, irq}, 8'h01);
    cpu_u.wr(8'h9a, 8'h80);
    cpu_u.wr(8'h9c, 8'h10);
    @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    rc(8'h9a, 8'h80);
    cpu_u.wr(8'h9a, 8'h00);
    raw = 1'b1;
    repeat (5) @(negedge clk);
    chk({7'h0, pin}, 8'h00);
    $display("edge test done");
  endtask
  // clearing write lands on the edge that samples the rising pulse
  task automatic t_race();
    raw = 1'b0;
    repeat (5) @(negedge clk);
    cpu_u.wr(8'h9a, 8'h00);
    raw = 1'b1;
    @(negedge clk);
    cpu_u.wr(8'h9a, 8'h00);
    rc(8'h9a, 8'h60);
    $display("race test done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_mode();
    t_ctrl();
    t_edges();
    t_race();
    close_out();
  end
endmodule
`default_nettype wire
